//--- verif/sar_adc_strobe_sequencer_test.sv
// Self-checking bench for the strobe sequencer with a comparator model.
// Assumes the design and package compiled first; settle count cut to 20.
`timescale 1ns/10ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module sar_adc_strobe_sequencer_test;
  logic mclk = 0, reset_n = 0, convertStrobe_n = 1, readConvertSel = 0, upperByteSelect = 0;
  logic compareAbove, resultBusOe, conversionDone_n, converterPowerOn, mode;
  logic referencePowerOn, referenceSettled, trackHold, lastKeep = 1'b0;
  logic [7:0] resultBusOut;
  logic [15:0] dacCode, analogLevel = 16'h0000;
  int mismatches = 0, nTests = 0, seed = 53587, waited;
  always #12.5 mclk = ~mclk;
  sar_adc_strobe_sequencer #(.REF_SETTLE_CYCLES(20)) u_sar_adc_strobe_sequencer (
    .mclk(mclk), .reset_n(reset_n), .convertStrobe_n(convertStrobe_n),
    .readConvertSel(readConvertSel), .upperByteSelect(upperByteSelect),
    .compareAbove(compareAbove), .resultBusOut(resultBusOut), .resultBusOe(resultBusOe),
    .conversionDone_n(conversionDone_n), .converterPowerOn(converterPowerOn),
    .referencePowerOn(referencePowerOn), .referenceSettled(referenceSettled),
    .trackHold(trackHold), .dacCode(dacCode));
  sarseq_front_end u_sarseq_front_end (.mclk(mclk), .trackHold(trackHold), .dacCode(dacCode),
    .analogLevel(analogLevel), .compareAbove(compareAbove));
  function automatic logic [7:0] expByte(input logic [15:0] r, input logic hi);
    return hi ? r[15:8] : r[7:0];
  endfunction : expByte
  task automatic stopTest;
    $display("Comparisons %0d, mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stopTest
  task automatic fall(input logic sel);
    @(negedge mclk);
    readConvertSel = sel;
    convertStrobe_n = 0;
    repeat (2) @(negedge mclk);
  endtask : fall
  task automatic rise;
    convertStrobe_n = 1;
    repeat (2) @(negedge mclk);
  endtask : rise
  // ----------------------------------------------------------------
  // Main sequence: corner levels first, then random ones
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(negedge mclk);
    reset_n = 1;
    for (int i = 0; i < 8; i++) begin
      analogLevel = (i < 3) ? 16'(i * 16'h7fff + i / 2) : 16'($random(seed));
      mode = (i < 4) ? 1'(i % 2) : 1'($random(seed));
      fall(1);
      rise;
      `CHK(trackHold, 1'b0)
      fall(0);
      rise;
      `CHK({trackHold, converterPowerOn, referencePowerOn}, 3'b111)
      `CHK(referenceSettled, lastKeep)
      `CHK(dacCode, sarseq_pkg::SAR_START)
      repeat (25) @(negedge mclk);
      `CHK(referenceSettled, 1'b1)
      fall(mode);
      `CHK({trackHold, conversionDone_n, converterPowerOn}, 3'b011)
      waited = 0;
      while (conversionDone_n !== 1'b0 && waited < 300) begin
        @(negedge mclk);
        waited++;
      end
      `CHK(waited + 2 <= sarseq_pkg::CONV_MAX_CYCLES, 1'b1)
      `CHK({converterPowerOn, referencePowerOn}, {1'b0, ~mode})
      rise;
      fall(1);
      `CHK(resultBusOut, expByte(analogLevel, 1'b0))
      upperByteSelect = 1;
      repeat (2) @(negedge mclk);
      `CHK(resultBusOut, expByte(analogLevel, 1'b1))
      `CHK({resultBusOe, referencePowerOn}, {1'b1, ~mode})
      upperByteSelect = 0;
      rise;
      `CHK(resultBusOe, 1'b0)
      fall(1);
      `CHK(resultBusOe, 1'b0)
      rise;
      lastKeep = ~mode;
    end
    stopTest();
  end
  // Eight passes take about 1800 cycles; far beyond that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stopTest();
  end
endmodule : sar_adc_strobe_sequencer_test

//--- verif/sarseq_asserts.sv
// Port checker for the strobe sequencer, bound into every instance.
// Assumes one mclk domain and a conversion shorter than 188 cycles.
`timescale 1ns/10ps
module sarseq_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic convertStrobe_n,
  input wire logic readConvertSel,
  input wire logic resultBusOe,
  input wire logic conversionDone_n,
  input wire logic converterPowerOn,
  input wire logic referencePowerOn,
  input wire logic trackHold
);
  logic strobePrev;
  logic modeHigh;
  logic strobeFall;
  assign strobeFall = strobePrev && !convertStrobe_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge mclk) begin
    strobePrev <= reset_n ? convertStrobe_n : 1'b1;
  end
  // Mode picked at the hold edge decides the reference state at done
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      modeHigh <= 1'b0;
    end else if (strobeFall && trackHold) begin
      modeHigh <= readConvertSel;
    end
  end
  a_bus_quiet_busy: assert property ((trackHold || converterPowerOn) |-> !resultBusOe)
    else $error("Result bus driven while busy");
  a_idle_fall_ignored: assert property (strobeFall && readConvertSel && conversionDone_n
    && !converterPowerOn |=> !trackHold && !resultBusOe) else $error("Idle fall not ignored");
  a_acquire_start: assert property (strobeFall && !readConvertSel && !converterPowerOn
    |=> trackHold && converterPowerOn && referencePowerOn) else $error("Acquire did not start");
  a_hold_edge: assert property (strobeFall && trackHold |=> !trackHold && converterPowerOn)
    else $error("Hold edge missed");
  a_done_bound: assert property ($fell(trackHold) |-> ##[1:187] !conversionDone_n)
    else $error("Done flag late");
  a_done_mode: assert property ($fell(conversionDone_n) |-> referencePowerOn == !modeHigh)
    else $error("Wrong low-power state after conversion");
  a_done_stands: assert property ($rose(conversionDone_n) |-> trackHold)
    else $error("Done flag dropped outside acquire start");
  a_read_drive: assert property ($rose(resultBusOe) |-> !$past(convertStrobe_n)
    && $past(readConvertSel) && !$past(conversionDone_n)) else $error("Bus driven without read");
  a_bus_release: assert property (resultBusOe && convertStrobe_n |=> !resultBusOe)
    else $error("Bus not released");
  a_read_ref_mode: assert property (resultBusOe |-> referencePowerOn == !modeHigh)
    else $error("Reference state wrong during read");
endmodule : sarseq_asserts

bind sar_adc_strobe_sequencer sarseq_asserts u_sarseq_asserts (.mclk(mclk), .reset_n(reset_n),
  .convertStrobe_n(convertStrobe_n), .readConvertSel(readConvertSel),
  .resultBusOe(resultBusOe), .conversionDone_n(conversionDone_n),
  .converterPowerOn(converterPowerOn), .referencePowerOn(referencePowerOn),
  .trackHold(trackHold));

//--- verif/sarseq_front_end.sv
// Analog front end stand-in: tracks a level, holds it, answers DAC trials.
// Assumes trackHold and dacCode come from the sequencer on mclk.
`timescale 1ns/10ps
module sarseq_front_end (
  input wire logic mclk,
  input wire logic trackHold,
  input wire logic [15:0] dacCode,
  input wire logic [15:0] analogLevel,
  output logic compareAbove
);
  logic [15:0] heldLevel = 16'h0000;
  // Frozen while holding, so a late input change cannot leak into the result
  always_ff @(posedge mclk) begin
    if (trackHold) begin
      heldLevel <= analogLevel;
    end
  end
  assign compareAbove = (heldLevel >= dacCode);
endmodule : sarseq_front_end

//--- verilog/sar_adc_strobe_sequencer.sv
// Strobe-driven sequencer of a 16-bit successive-approximation converter.
// Assumes strobe, select and byte-select inputs are synchronous to mclk, and an analog
// front end that samples while trackHold is high and answers each DAC trial on compareAbove.
//
// What this block does
// - First strobe fall with select low powers up and starts acquiring.
// - A cycle-starting strobe fall with select high is ignored.
// - Select level at the second strobe fall picks the post-conversion state.
// - Select low at second fall: standby afterwards, reference stays powered.
// - Select high at second fall: shutdown afterwards, reference powered down.
// - In standby a strobe fall with select low starts acquisition at once.
// - In shutdown such a fall wakes reference and acquires; 12 ms to full accuracy.
// - Done flag goes low at end of conversion, result valid.
// - Result bus undriven during acquisition and conversion.
// - Third strobe fall with select high drives the result after a delay.
// - Strobe returning high after a read releases the result bus.
// - After a read, the next strobe fall is needed for a new cycle.
// - Byte select low gives the low byte, high gives the high byte.
// - Result is offset binary over the full 16-bit range.
// - Second strobe fall ends acquisition, holds the sample, starts converting.
// - Internally timed conversion; done falls within 4.7 us of the second fall.
// - Pin n carries bit n for the low byte, bit n+8 for the high byte.

`timescale 1ns/10ps

module sar_adc_strobe_sequencer #(
  parameter int REF_SETTLE_CYCLES = sarseq_pkg::REF_SETTLE_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic convertStrobe_n,
  input wire logic readConvertSel,
  input wire logic upperByteSelect,
  input wire logic compareAbove,
  output logic [7:0] resultBusOut,
  output logic resultBusOe,
  output logic conversionDone_n,
  output logic converterPowerOn,
  output logic referencePowerOn,
  output logic referenceSettled,
  output logic trackHold,
  output logic [15:0] dacCode
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // One SAR decision: drop the tried bit if the input is below the trial,
  // then try the next lower bit.
  function automatic logic [15:0] sarStep(
    input logic [15:0] code,
    input logic [3:0] index,
    input logic keep
  );
    logic [15:0] trial;
    trial = code;
    if (!keep) begin
      trial[index] = 1'b0;
    end
    if (index != 4'h0) begin
      trial[index - 4'h1] = 1'b1;
    end
    return trial;
  endfunction : sarStep

  // Power-down state picked by the select level latched at the hold edge
  function automatic sarseq_pkg::sarseq_state_type lowPowerState(input logic keepRef);
    return keepRef ? sarseq_pkg::SS_STANDBY : sarseq_pkg::SS_SHUTDOWN;
  endfunction : lowPowerState

  // Reference wanted in a given state. A read in shutdown mode leaves it down:
  // waking it only to drive the bus would waste the low-power choice.
  function automatic logic referenceWanted(
    input sarseq_pkg::sarseq_state_type st,
    input logic keep
  );
    logic wanted;
    wanted = 1'b1;
    if (st == sarseq_pkg::SS_SHUTDOWN) begin
      wanted = 1'b0;
    end else if (st == sarseq_pkg::SS_DRIVE) begin
      wanted = keep;
    end
    return wanted;
  endfunction : referenceWanted

  // ----------------------------------------------------------------
  // Strobe edge detection
  // ----------------------------------------------------------------
  logic strobePrev;
  logic strobeFall;
  logic strobeRise;

  // History starts at the idle high level, so a strobe held low through reset gives a fall in the first cycle after reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      strobePrev <= 1'b1;
    end else begin
      strobePrev <= convertStrobe_n;
    end
  end

  assign strobeFall = strobePrev & ~convertStrobe_n;
  assign strobeRise = ~strobePrev & convertStrobe_n;

  // ----------------------------------------------------------------
  // Sequence state
  // ----------------------------------------------------------------
  sarseq_pkg::sarseq_state_type state;
  sarseq_pkg::sarseq_state_type next_state;
  logic keepRef;
  logic resultUnread;
  logic [3:0] bitTimer;
  logic [3:0] bitIndex;
  logic [15:0] result;
  logic bitDecide;
  logic convDone;

  assign bitDecide = (state == sarseq_pkg::SS_CONVERT) && (bitTimer == sarseq_pkg::BIT_LAST);
  assign convDone = bitDecide && (bitIndex == 4'h0);

  always_comb begin
    next_state = state;
    unique case (state)
      sarseq_pkg::SS_SHUTDOWN, sarseq_pkg::SS_STANDBY: begin
        if (strobeFall && !readConvertSel) begin
          next_state = sarseq_pkg::SS_ACQUIRE;
        end else if (strobeFall && resultUnread) begin
          next_state = sarseq_pkg::SS_DRIVE;
        end
        // Any other fall with select high starts nothing
      end
      sarseq_pkg::SS_ACQUIRE: begin
        if (strobeFall) begin
          next_state = sarseq_pkg::SS_CONVERT;
        end
      end
      sarseq_pkg::SS_CONVERT: begin
        // Strobe edges during conversion have no effect
        if (convDone) begin
          next_state = lowPowerState(keepRef);
        end
      end
      sarseq_pkg::SS_DRIVE: begin
        if (strobeRise) begin
          next_state = lowPowerState(keepRef);
        end
      end
      // Unused codes fall back to shutdown so an upset cannot lock the sequencer
      default: begin
        next_state = sarseq_pkg::SS_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state <= sarseq_pkg::SS_SHUTDOWN;
    end else begin
      state <= next_state;
    end
  end

  // Mode choice sampled only at the hold edge
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      keepRef <= 1'b0;
    end else if (state == sarseq_pkg::SS_ACQUIRE && strobeFall) begin
      keepRef <= ~readConvertSel;
    end
  end

  // A finished result may be read once; reading it consumes it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resultUnread <= 1'b0;
    end else if (convDone) begin
      resultUnread <= 1'b1;
    end else if (next_state == sarseq_pkg::SS_ACQUIRE || next_state == sarseq_pkg::SS_DRIVE) begin
      resultUnread <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bitTimer <= 4'h0;
    end else if (state != sarseq_pkg::SS_CONVERT || bitTimer == sarseq_pkg::BIT_LAST) begin
      bitTimer <= 4'h0;
    end else begin
      bitTimer <= bitTimer + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bitIndex <= sarseq_pkg::MSB_INDEX;
    end else if (state != sarseq_pkg::SS_CONVERT) begin
      bitIndex <= sarseq_pkg::MSB_INDEX;
    end else if (bitDecide && bitIndex != 4'h0) begin
      bitIndex <= bitIndex - 4'h1;
    end
  end

  // Trial code starts at mid-scale, so the settled code is offset binary
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dacCode <= sarseq_pkg::SAR_START;
    end else if (state != sarseq_pkg::SS_CONVERT) begin
      dacCode <= sarseq_pkg::SAR_START;
    end else if (bitDecide) begin
      dacCode <= sarStep(dacCode, bitIndex, compareAbove);
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      result <= sarseq_pkg::RESULT_RESET;
    end else if (convDone) begin
      result <= sarStep(dacCode, bitIndex, compareAbove);
    end
  end

  // Done flag: low from end of conversion until the next acquisition begins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      conversionDone_n <= 1'b1;
    end else if (convDone) begin
      conversionDone_n <= 1'b0;
    end else if (next_state == sarseq_pkg::SS_ACQUIRE) begin
      conversionDone_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power and track/hold controls
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      converterPowerOn <= 1'b0;
      trackHold <= 1'b0;
    end else begin
      converterPowerOn <= next_state == sarseq_pkg::SS_ACQUIRE ||
                          next_state == sarseq_pkg::SS_CONVERT;
      trackHold <= next_state == sarseq_pkg::SS_ACQUIRE;
    end
  end

  // Reference stays up through standby; shutdown drops it, and a read
  // after a shutdown-mode conversion keeps it down
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      referencePowerOn <= 1'b0;
    end else begin
      referencePowerOn <= referenceWanted(next_state, keepRef);
    end
  end

  // Settle flag only informs the controller; conversions are not held off,
  // since the controller owns the wake wait.
  logic [sarseq_pkg::REF_TIMER_BITS-1:0] refTimer;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      refTimer <= '0;
      referenceSettled <= 1'b0;
    end else if (!referencePowerOn) begin
      refTimer <= '0;
      referenceSettled <= 1'b0;
    end else if (refTimer == sarseq_pkg::REF_TIMER_BITS'(REF_SETTLE_CYCLES - 1)) begin
      referenceSettled <= 1'b1;
    end else begin
      refTimer <= refTimer + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Result bus
  // ----------------------------------------------------------------
  // One register stage gives the output delay after the reading strobe fall
  // Byte select is followed with one cycle of lag; the controller allows for it
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resultBusOe <= 1'b0;
    end else begin
      resultBusOe <= next_state == sarseq_pkg::SS_DRIVE;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resultBusOut <= sarseq_pkg::BUS_RESET;
    end else begin
      resultBusOut <= upperByteSelect ? result[15:8] : result[7:0];
    end
  end

endmodule : sar_adc_strobe_sequencer

//--- verilog/sarseq_pkg.sv
// Constants shared by the converter strobe sequencer.
// Assumes a single 40 MHz system clock; all times are turned into cycle counts here.
package sarseq_pkg;

  // ----------------------------------------------------------------
  // Clock and conversion timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Longest time from the hold edge to the done flag
  localparam int CONV_TIME_NS = 4700;
  // Longest time rounds down to whole cycles
  localparam int CONV_MAX_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int RESULT_BITS = 16;
  // Two cycles kept back for the edge detect and the done register
  localparam int BIT_CYCLES = (CONV_MAX_CYCLES - 2) / RESULT_BITS;
  localparam logic [3:0] BIT_LAST = 4'(BIT_CYCLES - 1);
  localparam logic [3:0] MSB_INDEX = 4'(RESULT_BITS - 1);

  // ----------------------------------------------------------------
  // Reference wake time
  // ----------------------------------------------------------------
  localparam int REF_SETTLE_US = 12000;
  // Least time rounds up to whole cycles
  localparam int REF_SETTLE_CYCLES = (REF_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_TIMER_BITS = 19;

  // ----------------------------------------------------------------
  // Reset and start values
  // ----------------------------------------------------------------
  // Offset binary mid-scale: first trial of every conversion
  localparam logic [15:0] SAR_START = 16'h8000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0] BUS_RESET = 8'h00;

  typedef enum logic [2:0] {
    SS_SHUTDOWN,
    SS_STANDBY,
    SS_ACQUIRE,
    SS_CONVERT,
    SS_DRIVE
  } sarseq_state_type;

endpackage : sarseq_pkg
